// ==== inc/rcp_pkg.sv ====
// Purpose: Shared types and constants for the calibration / power-up configuration block
// Assumes: One clock (mclk), all event inputs come from logic on that clock
// Notes:   Config struct mirrors register bits 5:0; bits 7:6 are never stored
package rcp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int            RCP_ADDR_W    = 6;
  localparam int            RCP_DATA_W    = 8;
  localparam int            RCP_CFG_W     = 6;
  localparam int            RCP_RSVD_W    = RCP_DATA_W - RCP_CFG_W;
  localparam logic [5:0]    RCP_CFG_ADDR  = 6'h18;
  localparam logic [5:0]    RCP_CFG_RESET = 6'h04;
  localparam logic [1:0]    RCP_RSVD_VAL  = 2'h0;
  localparam logic [7:0]    RCP_RD_NONE   = 8'h00;

  // ----------------------------------------------------------------
  // Calibration modes and power-on timeout
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RCP_AC_NEVER  = 2'h0,
    RCP_AC_ENTRY  = 2'h1,
    RCP_AC_RETURN = 2'h2,
    RCP_AC_FOURTH = 2'h3
  } rcp_autocal_t;

  localparam logic [1:0]    RCP_RET_LAST  = 2'h3;
  localparam logic [1:0]    RCP_RET_STEP  = 2'h1;
  localparam int            RCP_RIPPLE_W  = 6;
  localparam int            RCP_EXP_W     = 9;
  localparam logic [8:0]    RCP_EXP_CNT0  = 9'h001;
  localparam logic [8:0]    RCP_EXP_CNT1  = 9'h010;
  localparam logic [8:0]    RCP_EXP_CNT2  = 9'h040;
  localparam logic [8:0]    RCP_EXP_CNT3  = 9'h100;

  typedef struct packed {
    rcp_autocal_t auto_calibration_select;
    logic [1:0]   power_on_timeout_select;
    logic         spare;
    logic         crystal_keep_on;
  } rcp_cfg_t;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [RCP_ADDR_W-1:0] addr;
    logic [RCP_DATA_W-1:0] wdata;
  } rcp_reg_req_t;

  typedef struct packed {
    logic idle_to_active;
    logic auto_return_idle;
    logic calibrate_strobe;
  } rcp_sm_evt_t;

  typedef enum logic [1:0] {
    RCP_T_OFF   = 2'b00,
    RCP_T_COUNT = 2'b01,
    RCP_T_READY = 2'b11
  } rcp_tmr_st_t;

  typedef struct packed {
    rcp_cfg_t              cfg;
    logic [RCP_DATA_W-1:0] rdata;
    logic [1:0]            ret_cnt;
    logic                  cal;
    logic                  crystal_oscillator_run;
  } rcp_top_st_t;

  // Timeout code to number of ripple-counter expirations
  function automatic logic [8:0] rcp_expire_count(input logic [1:0] code);
    unique case (code)
      2'h0: rcp_expire_count = RCP_EXP_CNT0;
      2'h1: rcp_expire_count = RCP_EXP_CNT1;
      2'h2: rcp_expire_count = RCP_EXP_CNT2;
      2'h3: rcp_expire_count = RCP_EXP_CNT3;
    endcase
  endfunction

endpackage

// ==== design/rcp_po_timer.sv ====
// Purpose: Power-on timeout after crystal start, counting ripple-counter expirations
// Assumes: start is a one-cycle pulse when the oscillator turns on; en low means it is off
// Notes:   One flop drives both ready outputs so they can never drift apart
`timescale 1ns/1ns
module rcp_po_timer
  import rcp_pkg::*;
#(
  parameter int RIPPLE_W = RCP_RIPPLE_W
) (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       en,
  input  wire logic       start,
  input  wire logic [1:0] timeout_sel,
  output logic            chip_ready_low,
  output logic            crystal_stable
);
  import rcp_pkg::*;

  typedef struct packed {
    rcp_tmr_st_t          st;
    logic [RIPPLE_W-1:0]  ripple;
    logic [RCP_EXP_W-1:0] expires;
    logic [RCP_EXP_W-1:0] target;
    logic                 ready;
  } rcp_tmr_q_t;

  localparam logic [RIPPLE_W-1:0] RIPPLE_MAX = {RIPPLE_W{1'b1}};
  localparam logic [RIPPLE_W-1:0] RIPPLE_ONE = {{(RIPPLE_W-1){1'b0}}, 1'b1};
  localparam logic [8:0]          EXP_ONE    = 9'h001;

  rcp_tmr_q_t s_q;
  rcp_tmr_q_t s_d;

  always_comb begin
    s_d = s_q;
    if (!en) begin
      s_d.st    = RCP_T_OFF;
      s_d.ready = 1'b0;
    end else if (start) begin
      s_d.st      = RCP_T_COUNT;
      s_d.ripple  = '0;
      s_d.expires = '0;
      s_d.target  = rcp_expire_count(timeout_sel);
      s_d.ready   = 1'b0;
    end else begin
      unique case (s_q.st)
        RCP_T_COUNT: begin
          s_d.ripple = s_q.ripple + RIPPLE_ONE;
          if (s_q.ripple == RIPPLE_MAX) begin
            s_d.expires = s_q.expires + EXP_ONE;
            if (s_q.expires == s_q.target - EXP_ONE) begin
              s_d.st    = RCP_T_READY;
              s_d.ready = 1'b1;
            end
          end
        end
        RCP_T_READY: s_d.ready = 1'b1;
        RCP_T_OFF:   s_d.ready = 1'b0;
        default:     s_d.st    = RCP_T_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Both indications from the same flop: no skew
  assign chip_ready_low = ~s_q.ready;
  assign crystal_stable = s_q.ready;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [31:0] cnt_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= '0;
    end else if (s_q.st == RCP_T_COUNT) begin
      cnt_q <= cnt_q + 32'd1;
    end
  end

  a_timeout_length: assert property (@(posedge mclk) disable iff (!arst_n)
    $rose(s_q.ready) |-> cnt_q == 32'(s_q.target) * (32'd1 << RIPPLE_W))
    else $error("ready after wrong number of expirations");

  a_ready_together: assert property (@(posedge mclk) disable iff (!arst_n)
    $fell(chip_ready_low) |-> $rose(crystal_stable) ##1 (crystal_stable != chip_ready_low))
    else $error("chip ready and crystal stable not together");

endmodule

// ==== design/rcp_config.sv ====
// Purpose: Calibration and power-up configuration register with its control effects
// Assumes: Event inputs are single-cycle pulses from the main state machine on mclk
// Notes:   Register read data is captured on the read strobe and held until the next read
`timescale 1ns/1ns

// How it works
// - With auto-calibration select zero, calibration starts only on the manual strobe.
// - With select one, each move from idle into receive, transmit or synth-ready calibrates.
// - With select two, each automatic return from receive or transmit to idle calibrates.
// - With select three, only every fourth automatic return to idle calibrates.
// - After the crystal starts, chip ready waits 1, 16, 64 or 256 ripple-counter expirations.
// - Crystal stable rises in the same cycle that chip ready goes low.
// - With crystal keep-on set, the crystal oscillator keeps running in sleep.
module rcp_config
  import rcp_pkg::*;
#(
  parameter int RIPPLE_W = RCP_RIPPLE_W
) (
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire rcp_pkg::rcp_reg_req_t reg_req,
  output logic [7:0]                 reg_rdata,
  input  wire rcp_pkg::rcp_sm_evt_t  sm_evt,
  input  wire logic                  sleep_state,
  output logic                       calibrate_start,
  output logic                       crystal_osc_run,
  output logic                       chip_ready_low,
  output logic                       crystal_stable
);
  import rcp_pkg::*;

  rcp_top_st_t s_q;
  rcp_top_st_t s_d;
  logic        cfg_hit;
  logic        osc_start;
  logic        fourth_ret;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    cfg_hit    = (reg_req.addr == RCP_CFG_ADDR);
    fourth_ret = 1'b0;

    // Bits 7:6 are never stored, so writes to them vanish
    if (reg_req.wr && cfg_hit) begin
      s_d.cfg = rcp_cfg_t'(reg_req.wdata[RCP_CFG_W-1:0]);
    end
    // Read data is a snapshot; a later write does not refresh it
    if (reg_req.rd) begin
      s_d.rdata = cfg_hit ? {RCP_RSVD_VAL, s_q.cfg} : RCP_RD_NONE;
    end

    // Manual strobe always calibrates, whatever the mode
    s_d.cal = sm_evt.calibrate_strobe;
    unique case (s_q.cfg.auto_calibration_select)
      RCP_AC_NEVER: ;
      RCP_AC_ENTRY: begin
        if (sm_evt.idle_to_active) s_d.cal = 1'b1;
      end
      RCP_AC_RETURN: begin
        if (sm_evt.auto_return_idle) s_d.cal = 1'b1;
      end
      // Count survives mode changes, so a later switch to mode three
      // resumes where it stopped rather than at zero
      RCP_AC_FOURTH: begin
        if (sm_evt.auto_return_idle) begin
          s_d.ret_cnt = s_q.ret_cnt + RCP_RET_STEP;
          fourth_ret  = (s_q.ret_cnt == RCP_RET_LAST);
          if (fourth_ret) s_d.cal = 1'b1;
        end
      end
    endcase

    // Oscillator runs whenever not asleep, or in sleep if kept on
    s_d.crystal_oscillator_run = ~sleep_state | s_q.cfg.crystal_keep_on;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q          <= '0;
      s_q.cfg      <= rcp_cfg_t'(RCP_CFG_RESET);
    end else begin
      s_q          <= s_d;
    end
  end

  assign osc_start       = s_d.crystal_oscillator_run & ~s_q.crystal_oscillator_run;
  assign reg_rdata       = s_q.rdata;
  assign calibrate_start = s_q.cal;
  assign crystal_osc_run = s_q.crystal_oscillator_run;

  // ----------------------------------------------------------------
  // Power-on timeout
  // ----------------------------------------------------------------
  // Restarted on every oscillator start, so a short wake re-times fully
  rcp_po_timer #(
    .RIPPLE_W       (RIPPLE_W)
  ) u_po_timer (
    .mclk           (mclk),
    .arst_n         (arst_n),
    .en             (s_d.crystal_oscillator_run),
    .start          (osc_start),
    .timeout_sel    (s_q.cfg.power_on_timeout_select),
    .chip_ready_low (chip_ready_low),
    .crystal_stable (crystal_stable)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_never_auto_cal: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_q.cfg.auto_calibration_select == RCP_AC_NEVER && !sm_evt.calibrate_strobe)
      |=> !calibrate_start)
    else $error("calibration without manual strobe in manual mode");

  a_entry_cal: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_q.cfg.auto_calibration_select == RCP_AC_ENTRY && sm_evt.idle_to_active)
      |=> calibrate_start)
    else $error("no calibration on leaving idle");

  a_return_cal: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_q.cfg.auto_calibration_select == RCP_AC_RETURN && sm_evt.auto_return_idle)
      |=> calibrate_start)
    else $error("no calibration on return to idle");

  a_fourth_return: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_q.cfg.auto_calibration_select == RCP_AC_FOURTH && sm_evt.auto_return_idle
      && !sm_evt.calibrate_strobe)
      |=> calibrate_start == ($past(s_q.ret_cnt) == RCP_RET_LAST))
    else $error("fourth-return calibration out of step");

  a_keep_on_sleep: assert property (@(posedge mclk) disable iff (!arst_n)
    sleep_state |=> crystal_osc_run == $past(s_q.cfg.crystal_keep_on))
    else $error("oscillator state in sleep does not follow keep-on");

  a_ready_drops_off: assert property (@(posedge mclk) disable iff (!arst_n)
    !s_d.crystal_oscillator_run |=> chip_ready_low && !crystal_stable)
    else $error("ready shown while oscillator is off");

  a_ready_same_cycle: assert property (@(posedge mclk) disable iff (!arst_n)
    crystal_stable == !chip_ready_low)
    else $error("crystal stable and chip ready differ");

  a_reg_readback: assert property (@(posedge mclk) disable iff (!arst_n)
    (reg_req.wr && cfg_hit) ##1 (reg_req.rd && cfg_hit && !reg_req.wr)
      |=> reg_rdata == {RCP_RSVD_VAL, $past(reg_req.wdata[RCP_CFG_W-1:0], 2)})
    else $error("config read back differs from write or reserved bits set");

  // ----------------------------------------------------------------
  // Mode exclusions, register side and oscillator
  // ----------------------------------------------------------------
  a_strobe_cal: assert property (@(posedge mclk) disable iff (!arst_n)
    sm_evt.calibrate_strobe |=> calibrate_start)
    else $error("manual strobe did not calibrate");

  a_no_event_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    (sm_evt == '0)
      |=> !calibrate_start)
    else $error("calibration without any event");

  a_entry_only: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_q.cfg.auto_calibration_select == RCP_AC_ENTRY && !sm_evt.idle_to_active
      && !sm_evt.calibrate_strobe) |=> !calibrate_start)
    else $error("calibration in entry mode without an entry");

  a_return_only: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_q.cfg.auto_calibration_select == RCP_AC_RETURN && !sm_evt.auto_return_idle
      && !sm_evt.calibrate_strobe) |=> !calibrate_start)
    else $error("calibration in return mode without a return");

  a_fourth_only: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_q.cfg.auto_calibration_select == RCP_AC_FOURTH && !sm_evt.auto_return_idle
      && !sm_evt.calibrate_strobe) |=> !calibrate_start)
    else $error("calibration in fourth-return mode without a return");

  a_count_steps: assert property (@(posedge mclk) disable iff (!arst_n)
    (s_q.cfg.auto_calibration_select == RCP_AC_FOURTH && sm_evt.auto_return_idle)
      |=> s_q.ret_cnt == $past(s_q.ret_cnt) + RCP_RET_STEP)
    else $error("return count did not advance");

  a_count_holds: assert property (@(posedge mclk) disable iff (!arst_n)
    !(s_q.cfg.auto_calibration_select == RCP_AC_FOURTH && sm_evt.auto_return_idle)
      |=> $stable(s_q.ret_cnt))
    else $error("return count moved without a counted return");

  a_write_lands: assert property (@(posedge mclk) disable iff (!arst_n)
    (reg_req.wr && cfg_hit)
      |=> s_q.cfg == $past(reg_req.wdata[RCP_CFG_W-1:0]))
    else $error("config write did not land");

  a_unmapped_read: assert property (@(posedge mclk) disable iff (!arst_n)
    (reg_req.rd && !cfg_hit) |=> reg_rdata == RCP_RD_NONE)
    else $error("unmapped read returned data");

  a_unmapped_write: assert property (@(posedge mclk) disable iff (!arst_n)
    (reg_req.wr && !cfg_hit) |=> $stable(s_q.cfg))
    else $error("unmapped write changed the config");

  a_rdata_holds: assert property (@(posedge mclk) disable iff (!arst_n)
    !reg_req.rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  a_rsvd_zero: assert property (@(posedge mclk) disable iff (!arst_n)
    reg_rdata[RCP_DATA_W-1:RCP_CFG_W] == RCP_RSVD_VAL)
    else $error("reserved bits read nonzero");

  a_awake_osc_on: assert property (@(posedge mclk) disable iff (!arst_n)
    !sleep_state |=> crystal_osc_run)
    else $error("oscillator off while awake");

  a_keep_ready: assert property (@(posedge mclk) disable iff (!arst_n)
    (sleep_state && s_q.cfg.crystal_keep_on && crystal_stable)
      |=> crystal_stable)
    else $error("ready lost in sleep with keep-on");

  a_ready_needs_osc: assert property (@(posedge mclk) disable iff (!arst_n)
    !crystal_osc_run |-> chip_ready_low)
    else $error("chip ready shown with oscillator off");

  a_start_not_ready: assert property (@(posedge mclk) disable iff (!arst_n)
    osc_start
      |=> chip_ready_low)
    else $error("chip ready shown at oscillator start");

endmodule

// ==== dv/rcp_host_model.sv ====
// Purpose: Host software model driving the configuration register strobe port
// Assumes: Tasks are entered just after a rising mclk edge
// Notes:   Released address and data show the inverse of the last value
`timescale 1ns/1ns
module rcp_host_model (
  input  wire logic                  mclk,
  output rcp_pkg::rcp_reg_req_t      reg_req,
  input  wire logic [7:0]            reg_rdata
);
  import rcp_pkg::*;

  initial begin
    reg_req = '0;
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_req.wr    = 1'b1;
    reg_req.addr  = a;
    reg_req.wdata = d;
    @(posedge mclk);
    #1;
    reg_req.wr    = 1'b0;
    reg_req.addr  = ~a;
    reg_req.wdata = ~d;
    // Idle edge, so the next call never re-drives in the same step
    @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    reg_req.rd   = 1'b1;
    reg_req.addr = a;
    @(posedge mclk);
    #1;
    reg_req.rd   = 1'b0;
    reg_req.addr = ~a;
    d = reg_rdata;
    @(posedge mclk);
    #1;
  endtask

  // Safe start-up timeout, code two
  task automatic boot();
    wr(RCP_CFG_ADDR, 8'h08);
  endtask
endmodule

// ==== dv/tb_radio_calibration_powerup_config.sv ====
// Purpose: Self-checking bench for the calibration / power-up configuration block
// Assumes: Ripple width shortened to 2, so one expiration is 4 cycles
// Notes:   Calibration events are one-hot; the return count is tracked here
`timescale 1ns/1ns
module tb_radio_calibration_powerup_config;
  import rcp_pkg::*;
  localparam int RW = 2;
  logic                mclk = 1'b0;
  logic                arst_n = 1'b0;
  rcp_reg_req_t        reg_req;
  logic [7:0]          reg_rdata;
  rcp_sm_evt_t         sm_evt = '0;
  logic                sleep_state = 1'b0;
  logic                calibrate_start, crystal_osc_run, chip_ready_low, crystal_stable;
  int                  miscompares = 0;
  int                  checks_done = 0;
  int                  seed = 67514;
  logic [1:0]          mode = 2'h0;
  logic [1:0]          ret_cnt = 2'h0;
  logic [7:0]          rv;

  always #5 mclk = ~mclk;

  rcp_host_model u_host (.mclk(mclk), .reg_req(reg_req), .reg_rdata(reg_rdata));
  rcp_config #(.RIPPLE_W(RW)) u_dut (
    .mclk(mclk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .sm_evt(sm_evt), .sleep_state(sleep_state), .calibrate_start(calibrate_start),
    .crystal_osc_run(crystal_osc_run), .chip_ready_low(chip_ready_low),
    .crystal_stable(crystal_stable));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic int exp_cycles(input logic [1:0] code);
    int n;
    n = (code == 2'h0) ? 1 : (code == 2'h1) ? 16 : (code == 2'h2) ? 64 : 256;
    return n * (2 ** RW);
  endfunction

  function automatic logic exp_cal(input logic [1:0] m, input logic [2:0] e, input logic [1:0] c);
    return e[0] || (e[2] && m == 2'h1) || (e[1] && (m == 2'h2 || (m == 2'h3 && c == 2'h3)));
  endfunction

  // Cycles with the crystal running but chip not yet ready
  task automatic measure(input int expn);
    int n;
    n = 0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge mclk);
      #1;
      chk("stable_vs_ready", {15'h0, ~chip_ready_low}, {15'h0, crystal_stable});
      if (crystal_osc_run === 1'b1 && chip_ready_low === 1'b1) begin
        n++;
      end
      if (chip_ready_low === 1'b0) begin
        chk("timeout_cycles", expn[15:0], n[15:0]);
        return;
      end
    end
    chk("ready_wait", 16'h0, 16'h1);
    test_done();
  endtask

  task automatic ev(input logic [2:0] e);
    sm_evt = e;
    @(posedge mclk);
    #1;
    chk("calibrate_start", {15'h0, exp_cal(mode, e, ret_cnt)}, {15'h0, calibrate_start});
    if (e[1] && mode == 2'h3) begin
      ret_cnt = ret_cnt + 2'h1;
    end
  endtask

  task automatic set_mode(input logic [1:0] m);
    // Events are pulses: drop the last one before the write
    sm_evt = '0;
    u_host.wr(RCP_CFG_ADDR, {2'h0, m, 4'h0});
    mode = m;
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    #1;
    chk("reset_ready", 16'h1, {15'h0, chip_ready_low});
    arst_n = 1'b1;
    measure(exp_cycles(2'h1));
    $display("test power_up done");
    u_host.rd(RCP_CFG_ADDR, rv);
    chk("cfg_reset", 16'h04, {8'h0, rv});
    u_host.wr(RCP_CFG_ADDR, 8'hff);
    u_host.rd(RCP_CFG_ADDR, rv);
    chk("cfg_rsvd", 16'h3f, {8'h0, rv});
    u_host.wr(6'h17, 8'h00);
    u_host.rd(RCP_CFG_ADDR, rv);
    chk("cfg_unmapped_wr", 16'h3f, {8'h0, rv});
    u_host.rd(6'h17, rv);
    chk("unmapped_rd", 16'h00, {8'h0, rv});
    u_host.wr(RCP_CFG_ADDR, 8'h02);
    u_host.rd(RCP_CFG_ADDR, rv);
    chk("cfg_bit1", 16'h02, {8'h0, rv});
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      u_host.wr(RCP_CFG_ADDR, {4'h0, c[1:0], 2'h0});
      sleep_state = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      chk("sleep_osc_off", 16'h0, {15'h0, crystal_osc_run});
      sleep_state = 1'b0;
      measure(exp_cycles(c[1:0]));
    end
    u_host.wr(RCP_CFG_ADDR, 8'h01);
    sleep_state = 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    chk("keep_on_osc", 16'h1, {15'h0, crystal_osc_run});
    chk("keep_on_ready", 16'h0, {15'h0, chip_ready_low});
    sleep_state = 1'b0;
    u_host.boot();
    $display("test timeout done");
    for (int m = 0; m < 4; m++) begin
      set_mode(m[1:0]);
      ev(3'b100);
      ev(3'b010);
      ev(3'b001);
    end
    for (int k = 0; k < 8; k++) begin
      ev(3'b010);
    end
    for (int i = 0; i < 120; i++) begin
      if (i % 10 == 0) begin
        set_mode(2'($random(seed)));
      end else begin
        rv = 8'($random(seed));
        ev((rv[1:0] == 2'h3) ? 3'b000 : 3'(1 << rv[1:0]));
      end
    end
    sm_evt = '0;
    $display("test calibration done");
    arst_n = 1'b0;
    ret_cnt = 2'h0;
    #1;
    chk("rst_cal", 16'h0, {15'h0, calibrate_start});
    chk("rst_osc", 16'h0, {15'h0, crystal_osc_run});
    chk("rst_ready", 16'h1, {15'h0, chip_ready_low});
    chk("rst_rdata", 16'h0, {8'h0, reg_rdata});
    repeat (2) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    u_host.rd(RCP_CFG_ADDR, rv);
    chk("cfg_rst_again", 16'h04, {8'h0, rv});
    $display("test reset done");
    test_done();
  end
endmodule
